/* File: src/ods_defs.svh */
`ifndef ODS_DEFS_SVH
`define ODS_DEFS_SVH

// ==========================================
// command word layout
`define ODS_WORD_BITS 16
`define ODS_KEY_MSB 15
`define ODS_KEY_LSB 12
`define ODS_SEL_MSB 11
`define ODS_SEL_LSB 8
`define ODS_DATA_MSB 7
`define ODS_DATA_LSB 0
`define ODS_KEY_VALUE 4'ha

// ==========================================
// reset values
`define ODS_OUT_RESET 8'h00
`define ODS_DIAG_RESET 8'h00
`define ODS_PROT_RESET 8'h00
`define ODS_FAULT_RESET 16'h0000
`define ODS_WORD_RESET 16'h0000
`define ODS_FAULT_ALL 16'hffff

// ==========================================
// bit counts within a word
`define ODS_LAST_BIT 4'hf
`define ODS_FIRST_BIT 4'h0

`endif

/* File: src/ods_pkg.sv */
package ods_pkg;

    // ==========================================
    // writing mode selector
    typedef enum logic [3:0] {
        ODS_SEL_OUTPUT = 4'b1100,
        ODS_SEL_DIAG = 4'b0011,
        ODS_SEL_PROT = 4'b1010
    } ods_sel_t;

    // ==========================================
    // per-channel fault code
    typedef enum logic [1:0] {
        ODS_FLT_NONE = 2'b00,
        ODS_FLT_OPEN = 2'b01,
        ODS_FLT_SHORT = 2'b10,
        ODS_FLT_OVC = 2'b11
    } ods_fault_t;

endpackage : ods_pkg

/* File: src/ods_spi.sv */
// Notes on behaviour
// - output high impedance while select is high
// - first sixteen bits out are fault register
// - then echo input delayed sixteen clocks
// - words travel least significant bit first
// - sample on rising, change on falling edge
// - bits 15..12 must be key 1010
// - bits 11..8 choose output, diag, protect
// - output mode: bit n-1 drives channel n
// - diag mode: one latches, zero non-latching
// - protect mode: one linear limit, zero switch-off
// - clear faults on aligned word with key
// - partial word discarded, registers unchanged
// - reset: off, non-latching, switch-off protection
// - valid fault data in every transfer
// - shift only while select low; the receive register rx still shifts on rising sclk while select is high
// - only first word reaches command register
// - channels six to eight OR parallel enables
// - reset pin clears registers, outputs off
// - two fault bits per channel, codes fixed
// - thermal shutdown at select fall reports ones
`timescale 1ns/1ps
`default_nettype none
`include "ods_defs.svh"

module ods_spi
    import ods_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic [2:0] parallel_channel_enable,
    input wire logic [15:0] fault_code,
    input wire logic [7:0] thermal_shutdown,
    output logic [7:0] driver_channel,
    output logic [7:0] diag_latch_mode,
    output logic [7:0] current_limit_mode
);

    // ==========================================
    // link domain, receive side (rising sclk)
    // frame_rst_n clears in_frame and the transmit-side state; the captured word, bit_cnt and
    // word_done survive select rising so the system side can judge them
    logic frame_rst_n;
    logic in_frame;
    logic [3:0] bit_cnt;
    logic word_done;
    logic frame_tog;
    logic [15:0] rx;
    logic [15:0] command_word;
    logic next_in_frame;
    logic [3:0] next_bit_cnt;
    logic next_word_done;
    logic next_frame_tog;
    logic [15:0] next_rx;
    logic [15:0] next_command_word;
    logic [3:0] bit_idx;
    logic done_prev;

    assign frame_rst_n = rst_n & ~cs_n;

    always_comb
    begin
        next_rx = {sdi, rx[15:1]};
        next_in_frame = 1'b1;
        bit_idx = in_frame ? bit_cnt : `ODS_FIRST_BIT;
        done_prev = in_frame ? word_done : 1'b0;
        next_bit_cnt = bit_idx + 4'h1;
        next_word_done = done_prev;
        next_frame_tog = in_frame ? frame_tog : ~frame_tog;
        next_command_word = command_word;
        if (bit_idx == `ODS_LAST_BIT && !done_prev)
        begin
            next_command_word = next_rx;
            next_word_done = 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            in_frame <= 1'b0;
        else
            in_frame <= next_in_frame;
    end

    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt <= `ODS_FIRST_BIT;
            word_done <= 1'b0;
            frame_tog <= 1'b0;
            rx <= `ODS_WORD_RESET;
            command_word <= `ODS_WORD_RESET;
        end
        else
        begin
            bit_cnt <= next_bit_cnt;
            word_done <= next_word_done;
            frame_tog <= next_frame_tog;
            rx <= next_rx;
            command_word <= next_command_word;
        end
    end

    // ==========================================
    // link domain, transmit side (falling sclk)
    logic [15:0] report;
    logic [3:0] fall_cnt;
    logic started;
    logic sdo_q;
    logic [3:0] next_fall_cnt;
    logic next_sdo_q;

    always_comb
    begin
        next_fall_cnt = (fall_cnt == `ODS_LAST_BIT) ? fall_cnt : fall_cnt + 4'h1;
        if (fall_cnt != `ODS_LAST_BIT)
            next_sdo_q = report[fall_cnt + 4'h1];
        else
            next_sdo_q = rx[0];
    end

    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            fall_cnt <= `ODS_FIRST_BIT;
            started <= 1'b0;
            sdo_q <= 1'b0;
        end
        else
        begin
            fall_cnt <= next_fall_cnt;
            started <= 1'b1;
            sdo_q <= next_sdo_q;
        end
    end

    // first bit must stand before any sclk edge, so it comes from the frozen report
    assign sdo = started ? sdo_q : report[0];
    assign sdo_oe = ~cs_n;

    // ==========================================
    // system domain synchronisers
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic [2:0] par_s1;
    logic [2:0] par_s2;
    logic [15:0] fc_s1;
    logic [15:0] fc_s2;
    logic [7:0] th_s1;
    logic [7:0] th_s2;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            par_s1 <= 3'h0;
            par_s2 <= 3'h0;
            fc_s1 <= `ODS_FAULT_RESET;
            fc_s2 <= `ODS_FAULT_RESET;
            th_s1 <= 8'h00;
            th_s2 <= 8'h00;
        end
        else
        begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            tog_s1 <= frame_tog;
            tog_s2 <= tog_s1;
            par_s1 <= parallel_channel_enable;
            par_s2 <= par_s1;
            fc_s1 <= fault_code;
            fc_s2 <= fc_s1;
            th_s1 <= thermal_shutdown;
            th_s2 <= th_s1;
        end
    end

    // ==========================================
    // frame end decision
    logic frame_end;
    logic aligned_ok;
    logic cmd_ok;
    logic [3:0] sel;

    assign frame_end = cs_s2 & ~cs_s3;
    assign sel = command_word[`ODS_SEL_MSB:`ODS_SEL_LSB];
    // link clock has stopped by now, so the captured word is stable
    assign aligned_ok = frame_end && (tog_s2 != tog_seen) && word_done
        && bit_cnt == `ODS_FIRST_BIT
        && command_word[`ODS_KEY_MSB:`ODS_KEY_LSB] == `ODS_KEY_VALUE;
    assign cmd_ok = aligned_ok;

    // ==========================================
    // command registers
    logic [7:0] out_cmd;
    logic [7:0] next_out_cmd;
    logic [7:0] next_diag;
    logic [7:0] next_prot;
    logic [7:0] next_driver;

    always_comb
    begin
        next_out_cmd = out_cmd;
        next_diag = diag_latch_mode;
        next_prot = current_limit_mode;
        if (cmd_ok)
        begin
            if (sel == ODS_SEL_OUTPUT)
                next_out_cmd = command_word[`ODS_DATA_MSB:`ODS_DATA_LSB];
            else if (sel == ODS_SEL_DIAG)
                next_diag = command_word[`ODS_DATA_MSB:`ODS_DATA_LSB];
            else if (sel == ODS_SEL_PROT)
                next_prot = command_word[`ODS_DATA_MSB:`ODS_DATA_LSB];
            // any other selector leaves the output, diag and protect registers alone
        end
        next_driver = next_out_cmd | {par_s2, 5'h00};
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_cmd <= `ODS_OUT_RESET;
            diag_latch_mode <= `ODS_DIAG_RESET;
            current_limit_mode <= `ODS_PROT_RESET;
            driver_channel <= `ODS_OUT_RESET;
            tog_seen <= 1'b0;
        end
        else
        begin
            out_cmd <= next_out_cmd;
            diag_latch_mode <= next_diag;
            current_limit_mode <= next_prot;
            driver_channel <= next_driver;
            if (frame_end)
                tog_seen <= tog_s2;
        end
    end

    // ==========================================
    // fault register, two bits per channel
    logic [15:0] fault_reg;
    logic [15:0] next_fault;
    logic [15:0] next_report;

    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++)
        begin : g_fault
            logic [1:0] cur;
            logic [1:0] base;
            assign cur = fc_s2[2*ch+1:2*ch];
            // a fault seen in the clearing cycle survives the clear
            assign base = aligned_ok ? ODS_FLT_NONE : fault_reg[2*ch+1:2*ch];
            always_comb
            begin
                if (!diag_latch_mode[ch])
                    next_fault[2*ch+1:2*ch] = cur;
                else if (cur != ODS_FLT_NONE && base != ODS_FLT_OVC)
                    next_fault[2*ch+1:2*ch] = cur;
                else
                    next_fault[2*ch+1:2*ch] = base;
            end
        end
    endgenerate

    always_comb
    begin
        next_report = report;
        // report is frozen while select is low so the link reads it steadily
        if (cs_s2)
            next_report = (|th_s2) ? `ODS_FAULT_ALL : fault_reg;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_reg <= `ODS_FAULT_RESET;
            report <= `ODS_FAULT_RESET;
        end
        else
        begin
            fault_reg <= next_fault;
            report <= next_report;
        end
    end

endmodule : ods_spi

`default_nettype wire

/* File: testbench/ods_spi_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ods_spi_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic [2:0] parallel_channel_enable,
    input wire logic [7:0] driver_channel,
    input wire logic [7:0] diag_latch_mode,
    input wire logic [7:0] current_limit_mode
);
    // ==========================================
    // frame history; select high clears it, so no reset is needed
    logic [15:0] hist;
    logic [5:0] cnt;
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            hist <= 16'h0000;
            cnt <= 6'h00;
        end
        else
        begin
            hist <= {sdi, hist[15:1]};
            cnt <= cnt + 6'h01;
        end
    end
    a_oe_tracks_select:
        assert property (@(posedge clock) disable iff (!rst_n) sdo_oe == !cs_n)
        else $error("sdo enable wrong");
    a_echo_delay_sixteen:
        assert property (@(posedge sclk) disable iff (cs_n || !rst_n) cnt >= 6'h10 |-> sdo == hist[0])
        else $error("echoed bit wrong");
    a_cfg_hold_frame:
        assert property (@(posedge clock) disable iff (!rst_n)
            !cs_n && $past(!cs_n) |-> $stable({diag_latch_mode, current_limit_mode}))
        else $error("mode changed in frame");
    a_drv_hold_frame:
        assert property (@(posedge clock) disable iff (!rst_n)
            !cs_n && $past(!cs_n) |-> $stable(driver_channel[4:0]))
        else $error("channel changed in frame");
    a_idle_no_change:
        assert property (@(posedge clock) disable iff (!rst_n)
            cs_n [*6] |-> $stable({driver_channel[4:0], diag_latch_mode, current_limit_mode}))
        else $error("change while idle");
    a_change_after_rise:
        assert property (@(posedge clock) disable iff (!rst_n)
            $changed({diag_latch_mode, current_limit_mode}) |-> cs_n && $past(cs_n, 2))
        else $error("mode change without select rise");
    a_par_forces_on:
        assert property (@(posedge clock) disable iff (!rst_n)
            (parallel_channel_enable == 3'h7) [*5] |-> driver_channel[7:5] == 3'h7)
        else $error("parallel enable ignored");
    a_reset_clears_all:
        assert property (@(posedge clock) disable iff (!rst_n)
            $rose(rst_n) |-> {driver_channel, diag_latch_mode, current_limit_mode} == 24'h000000)
        else $error("not cleared by reset");
    c_long_frame: cover property (@(posedge sclk) !cs_n && cnt == 6'h1f);
    c_drv_update: cover property (@(posedge clock) $changed(driver_channel[4:0]));
    c_par_on: cover property (@(posedge clock) parallel_channel_enable == 3'h7);
endmodule : ods_spi_asserts
bind ods_spi ods_spi_asserts u_chk (.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .parallel_channel_enable(parallel_channel_enable),
    .driver_channel(driver_channel), .diag_latch_mode(diag_latch_mode),
    .current_limit_mode(current_limit_mode));
`default_nettype wire

/* File: testbench/ods_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none
module ods_spi_master (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_line
);
    logic [31:0] rx;
    event done;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
    end
    // ==========================================
    // one frame; link clock idles low, data line rests at its pull-up
    task automatic xfer(input logic [31:0] w, input int n, input int gap);
        rx = 32'h0;
        cs_n = 1'b0;
        #(300 + gap);
        for (int k = 0; k < n; k++)
        begin
            sdi = w[k];
            #7.5 sclk = 1'b1;
            rx[k] = sdo_line;
            #7.5 sclk = 1'b0;
        end
        #100 cs_n = 1'b1;
        sdi = 1'b1;
        ->done;
    endtask : xfer
endmodule : ods_spi_master
`default_nettype wire

/* File: testbench/ods_spi_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ods_spi_tb;
    import ods_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] par = 3'h0;
    logic [15:0] fcode = 16'h0000;
    logic [7:0] therm = 8'h00;
    logic [7:0] drv = 8'h00, dg = 8'h00, lm = 8'h00, d;
    logic [15:0] fr;
    logic [55:0] q[$];
    logic [55:0] e;
    logic [3:0] sels [4] = '{ODS_SEL_OUTPUT, ODS_SEL_DIAG, ODS_SEL_PROT, 4'h5};
    int failures = 0;
    int total_checks = 0;
    wire sclk, cs_n, sdi, sdo, sdo_oe, sdo_line;
    wire [7:0] driver_channel, diag_latch_mode, current_limit_mode;
    assign sdo_line = sdo_oe ? sdo : 1'bz;
    always #50 clock = ~clock;
    ods_spi_master u_m (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));
    ods_spi u_dut (.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .parallel_channel_enable(par), .fault_code(fcode),
        .thermal_shutdown(therm), .driver_channel(driver_channel),
        .diag_latch_mode(diag_latch_mode), .current_limit_mode(current_limit_mode));
    task bad(input string s);
        failures++;
        $display("wrong value at %0t: %s", $time, s);
    endtask : bad
    task results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task setin(input logic [2:0] p, input logic [15:0] f, input logic [7:0] t);
        @(posedge clock);
        par <= p;
        fcode <= f;
        therm <= t;
        repeat (6) @(posedge clock);
    endtask : setin
    // second word carries a valid key too, so only position keeps it out
    task cmd(input logic [3:0] key, input logic [3:0] sel, input logic [7:0] dat, input int n,
        input logic [15:0] rep);
        logic [31:0] w;
        logic [31:0] m;
        w = {4'ha, sel, ~dat, key, sel, dat};
        m = (n == 32) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
        // a frame that ends mid-word is refused whole, first word included
        if (key == 4'ha && n >= 16 && n % 16 == 0)
        begin
            if (sel == ODS_SEL_OUTPUT) drv = dat;
            if (sel == ODS_SEL_DIAG) dg = dat;
            if (sel == ODS_SEL_PROT) lm = dat;
        end
        q.push_back({{w[15:0], rep} & m, drv | {par, 5'h00}, dg, lm});
        u_m.xfer(w, n, $urandom_range(200));
        repeat (10) @(posedge clock);
    endtask : cmd
    always
    begin
        @(u_m.done);
        repeat (6) @(posedge clock);
        e = q.pop_front();
        total_checks += 2;
        if (u_m.rx !== e[55:24]) bad("serial output");
        if ({driver_channel, diag_latch_mode, current_limit_mode} !== e[23:0]) bad("modes");
    end
    initial
    begin
        repeat (8000) @(posedge clock);
        bad("timeout");
        results();
    end
    initial
    begin
        void'($urandom(32'hab44));
        fr = 16'($urandom()) & 16'hfffc;
        fcode <= fr;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        cmd(4'h5, ODS_SEL_OUTPUT, 8'hff, 16, fr);
        $display("test bad key done");
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($urandom()) | {7'h00, i == 1};
            cmd(4'ha, sels[i], d, 32, fr);
        end
        $display("test writing modes done");
        cmd(4'ha, ODS_SEL_OUTPUT, ~drv, 12, fr);
        setin(3'h0, fr | 16'h0001, 8'h00);
        setin(3'h0, fr, 8'h00);
        cmd(4'h5, ODS_SEL_DIAG, dg, 16, fr | 16'h0001);
        cmd(4'ha, ODS_SEL_DIAG, ~dg, 20, fr | 16'h0001);
        cmd(4'ha, ODS_SEL_DIAG, dg, 16, fr | 16'h0001);
        cmd(4'h5, ODS_SEL_DIAG, dg, 16, fr);
        $display("test latch and clear done");
        setin(3'h7, fr, 8'h10);
        cmd(4'h5, ODS_SEL_OUTPUT, 8'h00, 16, 16'hffff);
        setin(3'h0, fr, 8'h00);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        drv = 8'h00;
        dg = 8'h00;
        lm = 8'h00;
        repeat (4) @(posedge clock);
        cmd(4'h5, ODS_SEL_OUTPUT, 8'h00, 16, fr);
        $display("test enables, thermal, reset done");
        results();
    end
endmodule : ods_spi_tb
`default_nettype wire
